/* shared/shsf_defines.vh */
// Constants for the sync header stream framer
`ifndef SHSF_DEFINES_VH
`define SHSF_DEFINES_VH

`define SHSF_BLK_PER_MB     32
`define SHSF_BLK_IDX_W      5
`define SHSF_PAYLOAD_W      64
`define SHSF_BLK_LEN_BITS   66
`define SHSF_BLK_LAST       5'h1F

`define SHSF_FMT_W          2
`define SHSF_FMT_CRC12      2'h0
`define SHSF_FMT_FEC        2'h2

`define SHSF_CRC_W          12
`define SHSF_CRC_POLY       12'h80F
`define SHSF_FEC_W          26
`define SHSF_FEC_POLY       26'h0220211

`define SHSF_EXT_END_BIT    22
`define SHSF_PILOT_LSB      27
`define SHSF_PILOT          5'h10

`define SHSF_HDR_ONE        2'h2
`define SHSF_HDR_ZERO       2'h1

`define SHSF_CRC_FIXED_ONES 32'h80A88888

`endif

/* verilog/shsf_parity_gen.v */
// Serial-equivalent LFSR parity over one payload block per cycle
`timescale 1ns/1ps
`default_nettype none
module shsf_parity_gen #(
	parameter                  WIDTH  = 12,
	parameter [WIDTH-1:0]      POLY   = 12'h80F,
	parameter                  DATA_W = 64
) (
	// Clock and reset
	input  wire                clk,
	input  wire                rstn,
	input  wire                ce,
	// Payload in
	input  wire                blk_step,
	input  wire                mb_first,
	input  wire [DATA_W-1:0]   blk_data,
	// Parity out
	output wire [WIDTH-1:0]    parity_next,
	output reg  [WIDTH-1:0]    state_q
);

	// Oldest transmitted bit first: data[DATA_W-1] down to data[0]
	function [WIDTH-1:0] step_block;
		input [WIDTH-1:0]  st;
		input [DATA_W-1:0] d;
		integer            i;
		reg   [WIDTH-1:0]  s;
		reg                fb;
		begin
			s = st;
			for (i = DATA_W - 1; i >= 0; i = i - 1) begin
				fb = s[WIDTH-1] ^ d[i];
				s  = {s[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
			end
			step_block = s;
		end
	endfunction

	// Zero seed at each multiblock start
	assign parity_next = step_block(mb_first ? {WIDTH{1'b0}} : state_q, blk_data);

	always @(posedge clk) begin
		if (!rstn) begin
			state_q <= {WIDTH{1'b0}};
		end else if (ce && blk_step) begin
			state_q <= parity_next;
		end
	end

endmodule // shsf_parity_gen
`default_nettype wire

/* verilog/shsf_emb_clock.v */
// Block, multiblock and extended multiblock phase counter
`timescale 1ns/1ps
`default_nettype none
`include "shsf_defines.vh"
module shsf_emb_clock #(
	parameter                        EMB_W = 8
) (
	// Clock and reset
	input  wire                      clk,
	input  wire                      rstn,
	input  wire                      ce,
	// Control
	input  wire                      phase_reset,
	input  wire [EMB_W-1:0]          emb_len,
	// Phase
	output reg  [`SHSF_BLK_IDX_W-1:0] blk_idx_q,
	output reg  [EMB_W-1:0]          mb_idx_q,
	output wire                      mb_first,
	output wire                      mb_last_blk,
	output wire                      emb_last_mb,
	output wire                      local_ext_multiblock_clock_edge
);

	// Zero length would never close an extended multiblock; treat as one
	wire [EMB_W-1:0] emb_last_idx = (emb_len == {EMB_W{1'b0}}) ?
		{EMB_W{1'b0}} : emb_len - {{(EMB_W-1){1'b0}}, 1'b1};

	assign mb_first    = (blk_idx_q == {`SHSF_BLK_IDX_W{1'b0}});
	assign mb_last_blk = (blk_idx_q == `SHSF_BLK_LAST);
	assign emb_last_mb = (mb_idx_q >= emb_last_idx);
	// One edge per 66*32*E line bits
	assign local_ext_multiblock_clock_edge   = mb_first && (mb_idx_q == {EMB_W{1'b0}});

	always @(posedge clk) begin
		if (!rstn) begin
			blk_idx_q <= {`SHSF_BLK_IDX_W{1'b0}};
			mb_idx_q  <= {EMB_W{1'b0}};
		end else if (ce) begin
			if (phase_reset) begin
				// Deterministic phase from the reference edge
				blk_idx_q <= {`SHSF_BLK_IDX_W{1'b0}};
				mb_idx_q  <= {EMB_W{1'b0}};
			end else begin
				blk_idx_q <= blk_idx_q + {{(`SHSF_BLK_IDX_W-1){1'b0}}, 1'b1};
				if (mb_last_blk) begin
					if (emb_last_mb) begin
						mb_idx_q <= {EMB_W{1'b0}};
					end else begin
						mb_idx_q <= mb_idx_q + {{(EMB_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end

endmodule // shsf_emb_clock
`default_nettype wire

/* verilog/shsf_framer.v */
// Transmit sync header stream framer for the 64B/66B link layer
// Overview of operation
// - Every 32 consecutive blocks form one multiblock.
// - Extended multiblock of E multiblocks must hold whole frames.
// - E equals one when a multiblock holds whole frames.
// - SYSREF resets the extended multiblock clock to a fixed phase.
// - Extended multiblock clock period is 66*32*E bit periods.
// - Sync header is always 01 or 10.
// - Header 10 sends a one, header 01 sends a zero.
// - Stream bits of 32 blocks in order form the 32-bit stream word.
// - Only CRC-12 and FEC stream formats; no CRC-3, no command channel.
// - Every stream word ends with pilot 00001.
// - Stream bit 22 is one only in the last multiblock of an extension.
// - CRC-12 of one multiblock is sent in the next multiblock.
// - Format select 0 gives CRC-12, 2 gives FEC.
// - All seven command bits in CRC format are sent as zero.
// - Parity covers 2048 payload bits; state cleared per multiblock.
// - FEC 26-bit parity of each multiblock goes in the next one.
// - CRC layout: CRC at 0-2,4-6,8-10,12-14; fixed ones; flag at 22.
// - FEC layout: parity 25..4 at 0-21, flag 22, parity 3..0 at 23-26.
// - FEC polynomial x^26+x^21+x^17+x^9+x^4+1.
`timescale 1ns/1ps
`default_nettype none
`include "shsf_defines.vh"
module shsf_framer #(
	parameter                          EMB_W = 8
) (
	// Clock, reset, enable
	input  wire                        clk,
	input  wire                        rstn,
	input  wire                        ce,
	// Configuration
	input  wire [`SHSF_FMT_W-1:0]      header_format_select,
	input  wire [EMB_W-1:0]            emb_len,
	// Phase reference pin
	input  wire                        sysref,
	// Scrambled payload in, one block per enabled cycle
	input  wire [`SHSF_PAYLOAD_W-1:0]  blk_data,
	// Framed block out
	output reg  [1:0]                  tx_header_q,
	output reg  [`SHSF_PAYLOAD_W-1:0]  tx_payload_q,
	output reg                         tx_valid_q,
	// Status
	output reg                         local_ext_multiblock_clock_q,
	output reg                         ext_multiblock_end_flag_q,
	output reg                         multiblock_end_pilot_q,
	output reg                         fmt_error_q
);

	// SYSREF pin crossing: three flops, change counts once stages two and three agree
	reg  sr_s1_q;
	reg  sr_s2_q;
	reg  sr_s3_q;
	reg  sr_level_q;
	wire sr_agree = (sr_s2_q == sr_s3_q);
	wire sr_rise  = sr_agree && sr_s3_q && !sr_level_q;

	always @(posedge clk) begin
		if (!rstn) begin
			sr_s1_q    <= 1'b0;
			sr_s2_q    <= 1'b0;
			sr_s3_q    <= 1'b0;
			sr_level_q <= 1'b0;
		end else if (ce) begin
			sr_s1_q <= sysref;
			sr_s2_q <= sr_s1_q;
			sr_s3_q <= sr_s2_q;
			if (sr_agree) begin
				sr_level_q <= sr_s3_q;
			end
		end
	end

	// Phase counters
	wire [`SHSF_BLK_IDX_W-1:0] blk_idx;
	wire [EMB_W-1:0]           mb_idx;
	wire                       mb_first;
	wire                       mb_last_blk;
	wire                       emb_last_mb;
	wire                       local_ext_multiblock_clock_edge;

	// A continuous reference at the extended multiblock rate lands on our own edge
	shsf_emb_clock #(
		.EMB_W       (EMB_W)
	) u_clock (
		.clk         (clk),
		.rstn        (rstn),
		.ce          (ce),
		.phase_reset (sr_rise),
		.emb_len     (emb_len),
		.blk_idx_q   (blk_idx),
		.mb_idx_q    (mb_idx),
		.mb_first    (mb_first),
		.mb_last_blk (mb_last_blk),
		.emb_last_mb (emb_last_mb),
		.local_ext_multiblock_clock_edge   (local_ext_multiblock_clock_edge)
	);

	// Parity generators run on every block; only the selected one is sent
	wire [`SHSF_CRC_W-1:0] crc_next;
	wire [`SHSF_FEC_W-1:0] fec_next;

	shsf_parity_gen #(
		.WIDTH       (`SHSF_CRC_W),
		.POLY        (`SHSF_CRC_POLY),
		.DATA_W      (`SHSF_PAYLOAD_W)
	) u_crc (
		.clk         (clk),
		.rstn        (rstn),
		.ce          (ce),
		.blk_step    (1'b1),
		.mb_first    (mb_first),
		.blk_data    (blk_data),
		.parity_next (crc_next),
		.state_q     ()
	);

	shsf_parity_gen #(
		.WIDTH       (`SHSF_FEC_W),
		.POLY        (`SHSF_FEC_POLY),
		.DATA_W      (`SHSF_PAYLOAD_W)
	) u_fec (
		.clk         (clk),
		.rstn        (rstn),
		.ce          (ce),
		.blk_step    (1'b1),
		.mb_first    (mb_first),
		.blk_data    (blk_data),
		.parity_next (fec_next),
		.state_q     ()
	);

	// Parity of the finished multiblock, held for the following one
	reg [`SHSF_CRC_W-1:0] crc_hold_q;
	reg [`SHSF_FEC_W-1:0] fec_hold_q;

	always @(posedge clk) begin
		if (!rstn) begin
			crc_hold_q <= {`SHSF_CRC_W{1'b0}};
		end else if (ce && mb_last_blk) begin
			crc_hold_q <= crc_next;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			fec_hold_q <= {`SHSF_FEC_W{1'b0}};
		end else if (ce && mb_last_blk) begin
			fec_hold_q <= fec_next;
		end
	end

	// Format is sampled at multiblock start so a word is never mixed
	wire fmt_is_fec = (header_format_select == `SHSF_FMT_FEC);
	wire fmt_is_crc = (header_format_select == `SHSF_FMT_CRC12);

	// Stream word candidates for the multiblock about to start
	localparam [31:0] CRC_ONES = `SHSF_CRC_FIXED_ONES;
	localparam [4:0]  PILOT    = `SHSF_PILOT;
	wire       [31:0] crc_word;
	wire       [31:0] fec_word;
	reg        [31:0] word_q;

	// Fixed ones keep the pilot pattern unique inside a CRC word
	assign crc_word[0]  = crc_hold_q[11];
	assign crc_word[1]  = crc_hold_q[10];
	assign crc_word[2]  = crc_hold_q[9];
	assign crc_word[3]  = CRC_ONES[3];
	assign crc_word[4]  = crc_hold_q[8];
	assign crc_word[5]  = crc_hold_q[7];
	assign crc_word[6]  = crc_hold_q[6];
	assign crc_word[7]  = CRC_ONES[7];
	assign crc_word[8]  = crc_hold_q[5];
	assign crc_word[9]  = crc_hold_q[4];
	assign crc_word[10] = crc_hold_q[3];
	assign crc_word[11] = CRC_ONES[11];
	assign crc_word[12] = crc_hold_q[2];
	assign crc_word[13] = crc_hold_q[1];
	assign crc_word[14] = crc_hold_q[0];
	assign crc_word[15] = CRC_ONES[15];
	// No command channel: its seven bits are always zero
	assign crc_word[16] = 1'b0;
	assign crc_word[17] = 1'b0;
	assign crc_word[18] = 1'b0;
	assign crc_word[19] = CRC_ONES[19];
	assign crc_word[20] = 1'b0;
	assign crc_word[21] = CRC_ONES[21];
	assign crc_word[`SHSF_EXT_END_BIT] = emb_last_mb;
	assign crc_word[23] = CRC_ONES[23];
	assign crc_word[24] = 1'b0;
	assign crc_word[25] = 1'b0;
	assign crc_word[26] = 1'b0;
	assign crc_word[31:`SHSF_PILOT_LSB] = PILOT;

	// FEC layout: high parity first, low four parity bits after the flag
	assign fec_word[0]  = fec_hold_q[25];
	assign fec_word[1]  = fec_hold_q[24];
	assign fec_word[2]  = fec_hold_q[23];
	assign fec_word[3]  = fec_hold_q[22];
	assign fec_word[4]  = fec_hold_q[21];
	assign fec_word[5]  = fec_hold_q[20];
	assign fec_word[6]  = fec_hold_q[19];
	assign fec_word[7]  = fec_hold_q[18];
	assign fec_word[8]  = fec_hold_q[17];
	assign fec_word[9]  = fec_hold_q[16];
	assign fec_word[10] = fec_hold_q[15];
	assign fec_word[11] = fec_hold_q[14];
	assign fec_word[12] = fec_hold_q[13];
	assign fec_word[13] = fec_hold_q[12];
	assign fec_word[14] = fec_hold_q[11];
	assign fec_word[15] = fec_hold_q[10];
	assign fec_word[16] = fec_hold_q[9];
	assign fec_word[17] = fec_hold_q[8];
	assign fec_word[18] = fec_hold_q[7];
	assign fec_word[19] = fec_hold_q[6];
	assign fec_word[20] = fec_hold_q[5];
	assign fec_word[21] = fec_hold_q[4];
	assign fec_word[`SHSF_EXT_END_BIT] = emb_last_mb;
	assign fec_word[23] = fec_hold_q[3];
	assign fec_word[24] = fec_hold_q[2];
	assign fec_word[25] = fec_hold_q[1];
	assign fec_word[26] = fec_hold_q[0];
	assign fec_word[31:`SHSF_PILOT_LSB] = PILOT;

	// Unsupported codes fall back to CRC-12 and raise the error flag
	wire [31:0] word_new = fmt_is_fec ? fec_word : crc_word;
	wire [31:0] word_cur = mb_first ? word_new : word_q;
	wire        strm_bit = word_cur[blk_idx];

	always @(posedge clk) begin
		if (!rstn) begin
			word_q <= 32'h00000000;
		end else if (ce && mb_first) begin
			word_q <= word_new;
		end
	end

	// Output block registers, one per output
	always @(posedge clk) begin
		if (!rstn) begin
			tx_header_q <= `SHSF_HDR_ZERO;
		end else if (ce) begin
			// Always a complementary pair
			tx_header_q <= strm_bit ? `SHSF_HDR_ONE : `SHSF_HDR_ZERO;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			tx_payload_q <= {`SHSF_PAYLOAD_W{1'b0}};
		end else if (ce) begin
			tx_payload_q <= blk_data;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			tx_valid_q <= 1'b0;
		end else if (ce) begin
			tx_valid_q <= 1'b1;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			local_ext_multiblock_clock_q <= 1'b0;
		end else if (ce) begin
			local_ext_multiblock_clock_q <= local_ext_multiblock_clock_edge;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			ext_multiblock_end_flag_q <= 1'b0;
		end else if (ce) begin
			ext_multiblock_end_flag_q <= emb_last_mb && mb_last_blk;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			multiblock_end_pilot_q <= 1'b0;
		end else if (ce) begin
			multiblock_end_pilot_q <= mb_last_blk;
		end
	end

	// Level follows the code in force for the word being sent
	always @(posedge clk) begin
		if (!rstn) begin
			fmt_error_q <= 1'b0;
		end else if (ce) begin
			if (mb_first) begin
				fmt_error_q <= !(fmt_is_crc || fmt_is_fec);
			end
		end
	end

endmodule // shsf_framer
`default_nettype wire

/* verif/shsf_framer_assertions.sv */
// Port-level checks for the sync header stream framer
`timescale 1ns/1ps
`default_nettype none
module shsf_framer_assertions #(parameter EMB_W = 8) (
	// Framer inputs
	input wire logic             clk,
	input wire logic             rstn,
	input wire logic             ce,
	input wire logic [1:0]       header_format_select,
	input wire logic [EMB_W-1:0] emb_len,
	input wire logic             sysref,
	input wire logic [63:0]      blk_data,
	// Framer outputs
	input wire logic [1:0]       tx_header_q,
	input wire logic [63:0]      tx_payload_q,
	input wire logic             tx_valid_q,
	input wire logic             local_ext_multiblock_clock_q,
	input wire logic             ext_multiblock_end_flag_q,
	input wire logic             multiblock_end_pilot_q,
	input wire logic             fmt_error_q
);
	// Index of the block on the outputs, resynced by the clock pulse
	logic [5:0] idx_q;
	always @(posedge clk)
		if (!rstn)
			idx_q <= 6'h3F;
		else if (ce)
			idx_q <= multiblock_end_pilot_q ? 6'h00 :
				local_ext_multiblock_clock_q ? 6'h01 : idx_q + 6'h01;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	hdr_legal_a: assert property (tx_valid_q |-> tx_header_q inside {2'h1, 2'h2})
		else $error("sync header not complementary");
	pilot_tail_a: assert property (multiblock_end_pilot_q && $past(ce) |-> tx_header_q == 2'h2 &&
		$past(tx_header_q) == 2'h1 && $past(tx_header_q, 4) == 2'h1) else $error("bad pilot");
	mb_len_a: assert property (multiblock_end_pilot_q |-> idx_q == 6'h1F)
		else $error("multiblock not 32 blocks");
	ext_pilot_a: assert property (ext_multiblock_end_flag_q |-> multiblock_end_pilot_q)
		else $error("end flag off multiblock end");
	emb_start_a: assert property (multiblock_end_pilot_q && ce |=>
		local_ext_multiblock_clock_q == $past(ext_multiblock_end_flag_q)) else $error("clock pulse");
	fmt_err_a: assert property (multiblock_end_pilot_q && ce |=>
		fmt_error_q == $past(header_format_select[0])) else $error("format error flag");
	freeze_a: assert property (!ce |=> $stable(tx_payload_q) && $stable(tx_header_q))
		else $error("outputs moved while disabled");
	payload_a: assert property (ce |=> tx_payload_q == $past(blk_data))
		else $error("payload not passed");
	cover property (ext_multiblock_end_flag_q);
	cover property (fmt_error_q);
	cover property ($rose(sysref) ##[1:8] local_ext_multiblock_clock_q);
endmodule // shsf_framer_assertions
bind shsf_framer shsf_framer_assertions #(.EMB_W(EMB_W)) u_chk (.clk(clk), .rstn(rstn), .ce(ce),
	.header_format_select(header_format_select), .emb_len(emb_len), .sysref(sysref),
	.blk_data(blk_data), .tx_header_q(tx_header_q), .tx_payload_q(tx_payload_q),
	.tx_valid_q(tx_valid_q), .local_ext_multiblock_clock_q(local_ext_multiblock_clock_q),
	.ext_multiblock_end_flag_q(ext_multiblock_end_flag_q),
	.multiblock_end_pilot_q(multiblock_end_pilot_q), .fmt_error_q(fmt_error_q));
`default_nettype wire

/* verif/shsf_rx_model.sv */
// Receiving end model: frames stream words, recomputes parity
`timescale 1ns/1ps
`default_nettype none
`include "shsf_defines.vh"
module shsf_rx_model #(parameter EMB_W = 8) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	// Link side
	input  wire logic [1:0]       fmt,
	input  wire logic [EMB_W-1:0] emb_len,
	input  wire logic [1:0]       hdr,
	input  wire logic [63:0]      pay,
	input  wire logic             local_ext_multiblock_clock,
	// Results
	output var  logic [31:0]      word_q,
	output var  logic [31:0]      exp_q,
	output var  logic             stb_q,
	output var  logic [7:0]       bad_q
);
	logic           en_q, skip_q;
	logic [4:0]     b;
	logic [EMB_W-1:0] m;
	logic [1:0]     fm;
	logic [25:0]    cs, fs, cp, fp;
	logic [31:0]    sh;
	wire  [EMB_W-1:0] last = (emb_len == '0) ? '0 : emb_len - 1'b1;
	initial bad_q = 8'h00;
	function [25:0] par(input [25:0] s, input [63:0] d, input x);
		integer i;
		reg     fb;
		for (i = 63; i >= 0; i = i - 1) begin
			fb = d[i] ^ (x ? s[25] : s[11]);
			s = (s << 1) ^ (fb ? (x ? `SHSF_FEC_POLY : {14'h0, `SHSF_CRC_POLY}) : 26'h0);
		end
		par = x ? s : {14'h0, s[11:0]};
	endfunction
	function [31:0] mk(input [11:0] c, input [25:0] f, input [1:0] fm, input eo);
		integer j;
		if (fm == 2'h2) begin
			mk = 32'h80000000;
			for (j = 0; j < 22; j = j + 1)
				mk[j] = f[25-j];
			for (j = 0; j < 4; j = j + 1)
				mk[23+j] = f[3-j];
		end else begin
			mk = 32'h80A88888;
			for (j = 0; j < 12; j = j + 1)
				mk[j+j/3] = c[11-j];
		end
		mk[22] = eo;
	endfunction
	always @(posedge clk) begin
		en_q <= ce & rstn;
		stb_q <= 1'b0;
		if (!rstn) begin
			b = 5'h00;
			m = '0;
			cp = 26'h0;
			fp = 26'h0;
			fm = fmt;
			skip_q <= 1'b0;
		end else if (en_q) begin
			// Phase jump cuts a multiblock; its parity is not defined
			if (local_ext_multiblock_clock && b != 5'h00)
				skip_q <= 1'b1;
			if (local_ext_multiblock_clock) begin
				b = 5'h00;
				m = '0;
			end
			if (b == 5'h00) begin
				cs = 26'h0;
				fs = 26'h0;
			end
			cs = par(cs, pay, 1'b0);
			fs = par(fs, pay, 1'b1);
			sh[b] = hdr[1];
			if (hdr[0] == hdr[1])
				bad_q <= bad_q + 8'h01;
			if (b == 5'h1F) begin
				word_q <= sh;
				exp_q <= mk(cp[11:0], fp, fm, m == last);
				stb_q <= ~skip_q;
				skip_q <= 1'b0;
				cp = cs;
				fp = fs;
				fm = fmt;
				m = (m == last) ? '0 : m + 1'b1;
			end
			b = b + 5'h01;
		end
	end
endmodule // shsf_rx_model
`default_nettype wire

/* verif/test_sync_header_stream_framer.sv */
// Self-checking bench for the sync header stream framer
`timescale 1ns/1ps
`default_nettype none
module test_sync_header_stream_framer;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic [1:0]  fmt = 2'h0;
	logic [7:0]  emb = 8'h01;
	logic        sysref = 1'b0;
	logic [63:0] data = 64'h0123456789ABCDEF;
	logic [1:0]  hdr;
	logic [63:0] pay;
	logic        vld, local_ext_multiblock_clock, eoe, eom, ferr, stb;
	logic [31:0] word, exp;
	logic [7:0]  bad;
	int          n_fail = 0;
	int          checks_done = 0;
	always #5 clk = ~clk;
	always @(negedge clk) data <= data * 64'h5851F42D4C957F2D + 64'h1;
	shsf_framer #(.EMB_W(8)) dut (.clk(clk), .rstn(rstn), .ce(ce), .header_format_select(fmt),
		.emb_len(emb), .sysref(sysref), .blk_data(data), .tx_header_q(hdr), .tx_payload_q(pay),
		.tx_valid_q(vld), .local_ext_multiblock_clock_q(local_ext_multiblock_clock), .ext_multiblock_end_flag_q(eoe),
		.multiblock_end_pilot_q(eom), .fmt_error_q(ferr));
	shsf_rx_model #(.EMB_W(8)) u_rx (.clk(clk), .rstn(rstn), .ce(ce), .fmt(fmt), .emb_len(emb),
		.hdr(hdr), .pay(pay), .local_ext_multiblock_clock(local_ext_multiblock_clock), .word_q(word), .exp_q(exp), .stb_q(stb), .bad_q(bad));
	task chk(input [63:0] seen, input [63:0] want);
		checks_done++;
		if (seen !== want) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task final_report;
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task restart(input [7:0] e, input [1:0] f);
		@(negedge clk);
		rstn = 1'b0;
		emb = e;
		fmt = f;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
	endtask
	task words(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(negedge clk);
				k++;
			end while (!stb && k < 80);
			chk({stb, word}, {1'b1, exp});
		end
	endtask
	task t_crc;
		restart(8'h03, 2'h0);
		words(7);
		chk(ferr, 1'b0);
		chk(vld, 1'b1);
	endtask
	task t_sysref;
		int n;
		n = 0;
		repeat (8) @(negedge clk);
		sysref = 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while (!local_ext_multiblock_clock && n < 12);
		chk(n, 5);
		words(4);
		sysref = 1'b0;
	endtask
	task t_fec;
		restart(8'h01, 2'h2);
		words(3);
		chk(ferr, 1'b0);
	endtask
	task t_codes;
		int c;
		restart(8'h00, 2'h0);
		for (c = 0; c < 4; c++) begin
			fmt = c[1:0];
			words(2);
			chk(ferr, c[0]);
		end
	endtask
	task t_ce;
		repeat (5) @(negedge clk);
		ce = 1'b0;
		repeat (3) @(negedge clk);
		ce = 1'b1;
		words(2);
	endtask
	initial begin
		#50000;
		n_fail++;
		final_report;
	end
	initial begin
		t_crc;
		t_sysref;
		t_fec;
		t_codes;
		t_ce;
		chk(bad, 8'h00);
		final_report;
	end
endmodule // test_sync_header_stream_framer
`default_nettype wire
